/* File: dv/programmable_logic_slice_assertions.sv */
// Port-level checker of the logic slice, bound to the slice
`timescale 1ns/1ns
module slice_checker (
  // Clock, reset and bus
  input wire logic clk,
  input wire logic reset,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  // Routing and chain
  input wire logic [1:0] dataSel,
  input wire logic wideIn,
  input wire logic carryIn,
  input wire logic [1:0] tableOut,
  input wire logic wideOut5,
  input wire logic wideOut6,
  input wire logic carryOut,
  input wire logic carryGen,
  input wire logic carryProp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  wide_five_a: assert property (wideOut5 == (dataSel[0] ? tableOut[1] : tableOut[0]))
    else $error("five input mux wrong");
  wide_six_a: assert property (wideOut6 == (dataSel[1] ? wideIn : wideOut5))
    else $error("six input mux wrong");
  gen_prop_excl_a: assert property (!(carryGen && carryProp))
    else $error("generate and propagate together");
  prop_pass_a: assert property (carryProp |-> carryOut == carryIn)
    else $error("propagate lost carry in");
  gen_carry_a: assert property (carryGen |-> carryOut)
    else $error("generate without carry out");
  read_wait_a: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
    else $error("read wait not one cycle");
  write_nowait_a: assert property (write |-> !waitrequest)
    else $error("write stalled");
  data_hold_a: assert property (!read |=> $stable(readdata))
    else $error("read data moved without read");
  // Main scenarios reached
  read_seen_c: cover property (read && !waitrequest);
  prop_seen_c: cover property (carryProp);
  chain_seen_c: cover property (dataSel[1] && wideIn);
endmodule : slice_checker

bind programmable_logic_slice slice_checker chk_u (.clk, .reset, .read, .write, .waitrequest, .readdata,
  .dataSel, .wideIn, .carryIn, .tableOut, .wideOut5, .wideOut6, .carryOut, .carryGen, .carryProp);

/* File: dv/programmable_logic_slice_tb_top.sv */
// Self-checking bench of the logic slice
`timescale 1ns/1ns
module programmable_logic_slice_tb_top;
  import slice_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} rd_t;
  logic clk = 0, reset = 1, read = 0, write = 0, ceIn = 0, lsrIn = 0, wrEnIn = 0, addSubIn = 0, sliceClkIn = 0;
  logic nbrCarry = 0, nbrWide = 0, carryIn, wideIn, waitrequest, wideOut5, wideOut6, carryOut, carryGen, carryProp;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, r;
  logic [3:0] tableIn0 = 4'h0, tableIn1 = 4'h0;
  logic [1:0] dataSel = 2'h0, tableOut, regOut, tb, a, b, q, ram [16];
  logic [15:0] t0, t1;
  logic [2:0] s, sum;
  int failures = 0, compares = 0, cycles = 0;
  rd_t expQ [$];
  ripple_fn_t fns [7] = '{FN_ADD, FN_SUB, FN_ADDSUB, FN_GE, FN_NE, FN_LE, FN_MULT};
  ripple_fn_t cfn [3] = '{FN_UP, FN_UDLOAD, FN_DOWN};
  always #5 clk = ~clk;
  programmable_logic_slice dut_u (.clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
    .tableIn0, .tableIn1, .dataSel, .ceIn, .lsrIn, .wrEnIn, .addSubIn, .sliceClkIn, .carryIn, .wideIn,
    .tableOut, .regOut, .wideOut5, .wideOut6, .carryOut, .carryGen, .carryProp);
  routing_fabric_model fab_u (.clk, .nbrCarry, .nbrWide, .carryIn, .wideIn);
  // ----------------------------------------
  // Bus master and checking
  // ----------------------------------------
  // One bus transfer; a read first notes its expected word
  task automatic bus(input logic rd, input logic [4:0] ad, input logic [31:0] d, input logic [31:0] m);
    if (rd)
      expQ.push_back('{d, m});
    @(posedge clk);
    address <= ad;
    writedata <= d;
    read <= rd;
    write <= !rd;
    // Waitrequest is taken at the rising edge, before that edge's own updates land
    do
      @(posedge clk);
    while (waitrequest);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  // One routed clock pulse, high for one system clock, low for the next
  task automatic pulse();
    sliceClkIn <= 1'b1;
    @(posedge clk);
    sliceClkIn <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task automatic results();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic checkRead(input rd_t n);
    compares++;
    if ((readdata & n.mask) !== (n.exp & n.mask))
    begin
      failures++;
      $display("CHECK FAILED readdata exp %h got %h", n.exp & n.mask, readdata & n.mask);
    end
  endtask : checkRead
  // Monitor takes the oldest note when read data stands; also the hang limit
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (read && !waitrequest)
      checkRead(expQ.pop_front());
    if (cycles == 6000)
    begin
      failures++;
      results();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'h21ef0d26));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    bus(0, 5'h14, 32'h5a, 32'h0);
    for (int i = 0; i < 24; i += 4)
      bus(1, i[4:0], 32'h0, 32'hffffffff);
    $display("reset test done");
    t0 = 16'($urandom);
    t1 = 16'($urandom);
    bus(0, ADDR_TABLE0, {16'h0, t0}, 32'h0);
    bus(0, ADDR_TABLE1, {16'h0, t1}, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      s = 3'($urandom);
      tableIn0 <= i[3:0];
      tableIn1 <= 4'(15 - i);
      dataSel <= s[1:0];
      nbrWide <= s[2];
      tb = {t1[15 - i], t0[i]};
      bus(1, ADDR_STATUS, {26'h0, s[1] ? s[2] : tb[s[0]], 1'b0, tb, tb}, 32'hff);
    end
    $display("logic test done");
    foreach (fns[k])
    begin
      bus(0, ADDR_MODE, {24'h0, 2'b01, fns[k], 2'b01}, 32'h0);
      repeat (6)
      begin
        r = $urandom;
        a = r[1:0];
        b = r[3:2];
        tableIn0 <= {1'b0, r[6], b[0], a[0]};
        tableIn1 <= {1'b0, r[7], b[1], a[1]};
        addSubIn <= r[4];
        nbrCarry <= r[5];
        // Third table input carries the multiplier partial product
        sum = (k == 6) ? {1'b0, a & {2{b[0]}}} + {1'b0, r[7:6]} + {2'b00, r[5]}
          : {1'b0, a} + {1'b0, (k == 1 || (k == 2 && !r[4])) ? ~b : b} + {2'b00, r[5]};
        if (k < 3 || k == 6)
          bus(1, ADDR_STATUS, {24'h0, 2'b01, 1'b0, sum, 2'b00}, 32'hdc);
        else
          bus(1, ADDR_STATUS, {24'h0, 2'b01, 1'b0, k == 3 ? a >= b : k == 4 ? a != b : a <= b, 4'h0}, 32'hd0);
      end
    end
    $display("ripple test done");
    bus(0, ADDR_MODE, 32'h2, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      ram[i] = 2'($urandom);
      tableIn0 <= i[3:0];
      dataSel <= ram[i];
      wrEnIn <= 1'b1;
      @(posedge clk);
    end
    wrEnIn <= 1'b0;
    for (int m = 2; m < 4; m++)
    begin
      bus(0, ADDR_MODE, m, 32'h0);
      for (int i = 0; i < 16; i++)
      begin
        tableIn0 <= i[3:0];
        tableIn1 <= i[3:0];
        wrEnIn <= (m == 3);
        dataSel <= ~ram[i];
        bus(1, ADDR_STATUS, {24'h0, m[1:0], 2'b00, ram[i], 2'b00}, 32'hdc);
      end
    end
    $display("memory test done");
    // Pseudo dual port: write at tableIn1 while reading at tableIn0
    wrEnIn <= 1'b0;
    bus(0, ADDR_MODE, 32'h82, 32'h0);
    repeat (4)
    begin
      r = $urandom;
      tableIn1 <= r[3:0];
      tableIn0 <= ~r[3:0];
      dataSel <= r[5:4];
      wrEnIn <= 1'b1;
      ram[r[3:0]] = r[5:4];
      @(posedge clk);
      wrEnIn <= 1'b0;
      bus(1, ADDR_STATUS, {24'h0, 2'b10, 2'b00, ram[~r[3:0]], 2'b00}, 32'hdc);
      tableIn0 <= r[3:0];
      bus(1, ADDR_STATUS, {24'h0, 2'b10, 2'b00, r[5:4], 2'b00}, 32'hdc);
    end
    $display("dual port test done");
    // Counters on the routed clock: rising edge, falling edge, then level latch
    for (int j = 0; j < 3; j++)
    begin
      r = $urandom;
      a = r[1:0];
      bus(0, ADDR_CTRL, 32'h4 + j, 32'h0);
      bus(0, ADDR_MODE, {24'h0, 2'b00, cfn[j], 2'b01}, 32'h0);
      tableIn0 <= {3'b000, a[0]};
      tableIn1 <= {3'b000, a[1]};
      addSubIn <= 1'b1;
      nbrCarry <= 1'b1;
      lsrIn <= 1'b1;
      pulse();
      lsrIn <= 1'b0;
      q = (j == 1) ? a : 2'b00;
      repeat (r[4:2])
      begin
        pulse();
        q = (j == 2) ? q - 2'b01 : q + 2'b01;
      end
      s = (j == 2) ? {1'b0, q} - 3'b001 : {1'b0, q} + 3'b001;
      bus(1, ADDR_STATUS, {24'h0, 2'b01, 1'b0, s, q}, 32'hdf);
    end
    // Async set shows on the register outputs with no routed clock edge
    bus(0, ADDR_CTRL, 32'h1c, 32'h0);
    lsrIn <= 1'b1;
    bus(1, ADDR_STATUS, 32'h3, 32'h3);
    lsrIn <= 1'b0;
    $display("register test done");
    results();
  end
endmodule : programmable_logic_slice_tb_top

/* File: dv/routing_fabric_model.sv */
// Neighbour slice and routing model feeding the chain inputs
`timescale 1ns/1ns
module routing_fabric_model (
  // Clock
  input wire logic clk,
  // Values the neighbour should present
  input wire logic nbrCarry,
  input wire logic nbrWide,
  // Chain signals into the slice
  output logic carryIn,
  output logic wideIn
);
  // ----------------------------------------
  // Neighbour outputs
  // ----------------------------------------
  // Registered so chain inputs move just after an edge, as a real neighbour does
  always_ff @(posedge clk)
  begin
    carryIn <= nbrCarry;
    wideIn <= nbrWide;
  end
endmodule : routing_fabric_model

/* File: logic/programmable_logic_slice.sv */
// One slice of a programmable function unit with its configuration slave
`timescale 1ns/1ns
module programmable_logic_slice #(
  parameter int SLICE_INDEX = 0,
  parameter logic [15:0] INIT0 = slice_pkg::TABLE_INIT,
  parameter logic [15:0] INIT1 = slice_pkg::TABLE_INIT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM configuration slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Routing inputs
  input wire logic [3:0] tableIn0,
  input wire logic [3:0] tableIn1,
  input wire logic [1:0] dataSel,
  input wire logic ceIn,
  input wire logic lsrIn,
  input wire logic wrEnIn,
  input wire logic addSubIn,
  input wire logic sliceClkIn,
  // Chain inputs
  input wire logic carryIn,
  input wire logic wideIn,
  // Routing outputs
  output logic [1:0] tableOut,
  output logic [1:0] regOut,
  output logic wideOut5,
  output logic wideOut6,
  // Chain outputs
  output logic carryOut,
  output logic carryGen,
  output logic carryProp
);
  import slice_pkg::*;

  // ------------------------------------------------------------
  // Configuration state
  // ------------------------------------------------------------
  logic [TABLE_BITS-1:0] tableBits [2];
  logic [7:0] modeCfg;
  logic [7:0] ctrlCfg;
  logic rdValid;
  logic busWrite;
  slice_mode_t mode;
  slice_mode_t effMode;
  ripple_fn_t fn;
  logic fast;
  logic dualPort;

  // Table lookup, shared by logic, ROM and RAM read paths
  function automatic logic lookup(input logic [15:0] bits, input logic [3:0] idx);
    lookup = bits[idx];
  endfunction : lookup

  assign mode = slice_mode_t'(modeCfg[MODE_LSB +: 2]);
  assign fn = ripple_fn_t'(modeCfg[FUNC_LSB +: 4]);
  assign fast = modeCfg[FAST_BIT];
  assign dualPort = modeCfg[DUAL_BIT];
  // The last slice has no RAM write path, so RAM there falls back to ROM
  assign effMode = (mode == MODE_RAM && SLICE_INDEX >= RAM_SLICE_LIMIT) ? MODE_ROM : mode;

  // ------------------------------------------------------------
  // Avalon slave
  // ------------------------------------------------------------
  // Reads wait one cycle for registered data; writes never wait
  assign waitrequest = read & ~rdValid;
  assign busWrite = write;

  always_ff @(posedge clk)
  begin
    if (reset)
      rdValid <= 1'b0;
    else
      rdValid <= read & ~rdValid;
  end

  // Mode and control words
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      modeCfg <= MODE_RESET;
      ctrlCfg <= CTRL_RESET;
    end
    else if (busWrite && address == ADDR_MODE)
      modeCfg <= writedata[7:0];
    else if (busWrite && address == ADDR_CTRL)
      ctrlCfg <= writedata[7:0];
  end

  // ------------------------------------------------------------
  // Register clocking
  // ------------------------------------------------------------
  logic clkPrev;
  logic rise;
  logic fall;
  logic edgeTick;
  logic levelOpen;
  logic captureEn;
  logic chipOk;

  always_ff @(posedge clk)
  begin
    if (reset)
      clkPrev <= 1'b0;
    else
      clkPrev <= sliceClkIn;
  end

  assign rise = sliceClkIn & ~clkPrev;
  assign fall = ~sliceClkIn & clkPrev;
  // Without clock select the registers follow the system clock
  assign edgeTick = ctrlCfg[CLKSEL_BIT] ? (ctrlCfg[NEG_BIT] ? fall : rise) : 1'b1;
  assign levelOpen = ctrlCfg[CLKSEL_BIT] ? (sliceClkIn ^ ctrlCfg[NEG_BIT]) : 1'b1;
  assign chipOk = ~ctrlCfg[CEUSE_BIT] | ceIn;
  assign captureEn = (ctrlCfg[LATCH_BIT] ? levelOpen : edgeTick) & chipOk;

  // ------------------------------------------------------------
  // Distributed memory
  // ------------------------------------------------------------
  logic ramWrite;
  logic [3:0] ramWrAddr;
  logic [3:0] ramRdAddr;

  // Pseudo dual port writes at tableIn1 while reading at tableIn0
  assign ramRdAddr = tableIn0;
  assign ramWrAddr = dualPort ? tableIn1 : tableIn0;
  assign ramWrite = (effMode == MODE_RAM) & wrEnIn & edgeTick & chipOk;

  // Bus loading has priority over a routing write in the same cycle
  for (genvar i = 0; i < 2; i++)
  begin : g_table
    always_ff @(posedge clk)
    begin
      if (reset)
        tableBits[i] <= (i == 0) ? INIT0 : INIT1;
      else if (busWrite && address == ((i == 0) ? ADDR_TABLE0 : ADDR_TABLE1))
        tableBits[i] <= writedata[15:0];
      else if (ramWrite)
        tableBits[i][ramWrAddr] <= dataSel[i];
    end
  end

  // ------------------------------------------------------------
  // Ripple arithmetic
  // ------------------------------------------------------------
  logic [1:0] opA;
  logic [1:0] opB;
  logic [1:0] opBx;
  logic [1:0] partial;
  logic [1:0] regQ;
  logic [2:0] addSum;
  logic [2:0] subSum;
  logic [2:0] upSum;
  logic [2:0] downSum;
  logic [2:0] sum;
  logic isSub;
  logic isAddType;
  logic [1:0] genBits;
  logic [1:0] propBits;

  assign opA = {tableIn1[0], tableIn0[0]};
  assign opB = {tableIn1[1], tableIn0[1]};
  assign partial = {tableIn1[2], tableIn0[2]};
  assign addSum = {1'b0, opA} + {1'b0, opB} + {2'b00, carryIn};
  // Carry in high means no borrow into a subtraction
  assign subSum = {1'b0, opA} + {1'b0, ~opB} + {2'b00, carryIn};
  // Counters step by the carry in, so a chain counts as one wide counter
  assign upSum = {1'b0, regQ} + {2'b00, carryIn};
  assign downSum = {1'b0, regQ} - {2'b00, carryIn};

  // Function select
  always_comb
  begin
    sum = 3'b000;
    isSub = 1'b0;
    isAddType = 1'b0;
    case (fn)
      FN_ADD:
      begin
        sum = addSum;
        isAddType = 1'b1;
      end
      FN_SUB:
      begin
        sum = subSum;
        isSub = 1'b1;
        isAddType = 1'b1;
      end
      FN_ADDSUB:
      begin
        sum = addSubIn ? addSum : subSum;
        isSub = ~addSubIn;
        isAddType = 1'b1;
      end
      FN_UP: sum = upSum;
      FN_DOWN: sum = downSum;
      FN_UDCLR, FN_UDLOAD: sum = addSubIn ? upSum : downSum;
      FN_GE: sum = {2'b00, opA >= opB};
      FN_NE: sum = {2'b00, opA != opB};
      FN_LE: sum = {2'b00, opA <= opB};
      FN_MULT: sum = {1'b0, opA & {2{opB[0]}}} + {1'b0, partial} + {2'b00, carryIn};
      default: sum = 3'b000;
    endcase
  end

  // Fast carry terms exist only for add-type functions
  assign opBx = isSub ? ~opB : opB;
  assign genBits = opA & opBx;
  assign propBits = opA ^ opBx;
  assign carryGen = fast & isAddType & (effMode == MODE_RIPPLE)
                    & (genBits[1] | (propBits[1] & genBits[0]));
  assign carryProp = fast & isAddType & (effMode == MODE_RIPPLE) & propBits[1] & propBits[0];

  // Carry output
  always_comb
  begin
    if (effMode != MODE_RIPPLE)
      carryOut = 1'b0;
    else if (fast && isAddType)
      carryOut = carryGen | (carryProp & carryIn);
    else if (fn == FN_GE || fn == FN_NE || fn == FN_LE)
      carryOut = sum[0];
    else
      carryOut = sum[2];
  end

  // ------------------------------------------------------------
  // Table outputs and wide functions
  // ------------------------------------------------------------
  logic [1:0] tableVal;

  always_comb
  begin
    tableVal = 2'b00;
    unique case (effMode)
      MODE_LOGIC, MODE_ROM:
      begin
        tableVal[0] = lookup(tableBits[0], tableIn0);
        tableVal[1] = lookup(tableBits[1], tableIn1);
      end
      MODE_RIPPLE: tableVal = sum[1:0];
      MODE_RAM:
      begin
        tableVal[0] = lookup(tableBits[0], ramRdAddr);
        tableVal[1] = lookup(tableBits[1], ramRdAddr);
      end
    endcase
  end

  assign tableOut = tableVal;
  assign wideOut5 = dataSel[0] ? tableVal[1] : tableVal[0];
  // Neighbour's wide output joins here to build six to eight inputs
  assign wideOut6 = dataSel[1] ? wideIn : wideOut5;

  // ------------------------------------------------------------
  // Storage registers
  // ------------------------------------------------------------
  logic counterFn;
  logic lsrIsAsync;
  logic lsrIsLoad;
  logic lsrValue;
  logic [1:0] regD;

  assign counterFn = (effMode == MODE_RIPPLE) && (fn inside {FN_UP, FN_DOWN, FN_UDCLR, FN_UDLOAD});
  // Clear counter forces an async clear to zero; preload counter loads A
  assign lsrIsAsync = ctrlCfg[ASYNC_BIT] | (counterFn & (fn == FN_UDCLR));
  assign lsrIsLoad = counterFn & (fn == FN_UDLOAD);
  assign lsrValue = ctrlCfg[SETVAL_BIT] & ~(counterFn & (fn == FN_UDCLR));

  for (genvar i = 0; i < 2; i++)
  begin : g_reg
    assign regD[i] = counterFn ? sum[i] : (ctrlCfg[DIRECT_BIT] ? dataSel[i] : tableVal[i]);

    always_ff @(posedge clk)
    begin
      if (reset)
        regQ[i] <= 1'b0;
      else if (lsrIn && (lsrIsAsync || captureEn))
        regQ[i] <= lsrIsLoad ? opA[i] : lsrValue;
      else if (captureEn)
        regQ[i] <= regD[i];
    end

    // An async set or reset shows at once, without waiting for a clock
    assign regOut[i] = (lsrIn && lsrIsAsync && !lsrIsLoad) ? lsrValue : regQ[i];
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      readdata <= 32'h0000_0000;
    else if (read && !rdValid)
    begin
      case (address)
        ADDR_TABLE0: readdata <= {16'h0000, tableBits[0]};
        ADDR_TABLE1: readdata <= {16'h0000, tableBits[1]};
        ADDR_MODE: readdata <= {24'h00_0000, modeCfg};
        ADDR_CTRL: readdata <= {24'h00_0000, ctrlCfg};
        ADDR_STATUS: readdata <= {24'h00_0000, effMode, wideOut6, carryOut, tableVal, regOut};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : programmable_logic_slice

/* File: logic/slice_pkg.sv */
// Constants, field layout and mode codes of the programmable logic slice
// ----------------------------------------------------------------------
// Functional notes
// - A slice holds two four-input tables whose outputs feed two storage registers of the same slice.
// - Only slices 0 to 2 of a function unit may act as writable RAM; slice 3 offers logic, ripple and ROM.
// - Set or reset, each sync or async, plus clock select, chip select and wide RAM/ROM support.
// - Registers capture on a rising or falling edge, or act as level latches of either polarity.
// - Fifteen routing inputs plus a carry input; six routing outputs plus a carry output.
// - In logic mode each table returns one programmed bit for each of its sixteen input codes.
// - The two tables of one slice combine into a five-input function.
// - Six to eight input functions chain across slices through the neighbour wide input.
// - Ripple mode adds, subtracts, or adds or subtracts under a dynamic control, two bits wide.
// - Ripple mode counts up, down, or up and down with async clear or sync preload, two bits wide.
// - Ripple mode compares A and B for greater-or-equal, not-equal, less-or-equal and builds multipliers.
// - With fast carry selected the slice drives carry generate and propagate terms for add, subtract and add/subtract functions.
// - RAM mode stores a 16-word memory in the tables, addressed and controlled by routing inputs.
// - Single port and pseudo dual port RAM both occupy three slices of the unit.
// - Table contents load with defined initial values before any write.
// ----------------------------------------------------------------------
package slice_pkg;
  // Byte addresses of the configuration words
  localparam logic [4:0] ADDR_TABLE0 = 5'h00;
  localparam logic [4:0] ADDR_TABLE1 = 5'h04;
  localparam logic [4:0] ADDR_MODE = 5'h08;
  localparam logic [4:0] ADDR_CTRL = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  localparam int TABLE_BITS = 16;
  localparam logic [15:0] TABLE_INIT = 16'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Mode word fields
  localparam int MODE_LSB = 0;
  localparam int FUNC_LSB = 2;
  localparam int FAST_BIT = 6;
  localparam int DUAL_BIT = 7;
  // Register control word fields
  localparam int NEG_BIT = 0;
  localparam int LATCH_BIT = 1;
  localparam int CLKSEL_BIT = 2;
  localparam int ASYNC_BIT = 3;
  localparam int SETVAL_BIT = 4;
  localparam int CEUSE_BIT = 5;
  localparam int DIRECT_BIT = 6;
  // Slices below this index may hold writable RAM
  localparam int RAM_SLICE_LIMIT = 3;
  localparam int RAM_SLICES = 3;

  typedef enum logic [1:0] {
    MODE_LOGIC = 2'b00,
    MODE_RIPPLE = 2'b01,
    MODE_RAM = 2'b10,
    MODE_ROM = 2'b11
  } slice_mode_t;

  typedef enum logic [3:0] {
    FN_ADD = 4'h0,
    FN_SUB = 4'h1,
    FN_ADDSUB = 4'h2,
    FN_UP = 4'h3,
    FN_DOWN = 4'h4,
    FN_UDCLR = 4'h5,
    FN_UDLOAD = 4'h6,
    FN_GE = 4'h7,
    FN_NE = 4'h8,
    FN_LE = 4'h9,
    FN_MULT = 4'ha
  } ripple_fn_t;
endpackage : slice_pkg
